// File: core/line_act_cfg.svh
// Purpose: constants for the ternary line activation signalling block
// Assumes: 200 MHz ref_clk, one clock domain
// Notes: codes and timings used by the design; the bench and checker repeat their own values
//
// Contract
// - network-side wake sends a 7.5 kHz tone for 2.13 ms
// - after the tone, raise the done flag and send ternary zero
// - while synchronizing send unframed scrambled zeros, no sync, no M
// - once synchronized send framed scrambled zeros, terminal not active
// - whole link synchronous: framed scrambled ones
// - transparent request seen: stop link-sync element, tell bus side
// - transparent state: framed user data from the system interface
// - continuous zero means deactivate downstream, acknowledged by zero upstream
// - framed training with sync word is the receive sync criterion
// - upstream M channel carries code errors and transparent data
// - only the exchange starts deactivation
// - bus frame before activation: B, D, echo and A bits zero
// - loopbacks are transparent: looped data also passes onward
// - loop closed: only looped data used, bus side user data ignored
// - looped B and D share one propagation delay
// - loop request forwarded as loop indication if transparent, else request
// - loop-induced bus resync exchanges codes at once
// - loop request code 1010, loop indication code 1110
`ifndef LINE_ACT_CFG_SVH
`define LINE_ACT_CFG_SVH
`define CLK_HZ 200000000.0
`define WAKE_TONE_HZ 7500.0
`define WAKE_DUR_MS 2.13
`define FRAME_SYMS 7'h78
`define SYNC_SYMS 7'h0B
`define M_POS 7'h77
`define SYNC_WORD 22'h15A9A6
`define SCRAM_TAPS 23'h420000
`define SCRAM_SEED 23'h7FFFFF
`define LOOP_CLOSE_CODE 8'hA5
`define LOOP_OPEN_CODE 8'h5A
`define CI_DEACT_REQ 4'h0
`define CI_RESYNC_IND 4'h4
`define CI_ACT_REQ 4'h8
`define CI_LOOP_ACT_REQ 4'hA
`define CI_ACT_IND 4'hC
`define CI_LOOP_ACT_IND 4'hE
`define CI_DEACT_CONF 4'hF
`define WORD_BITS 5'h12
`endif

// File: core/line_act_pkg.sv
// Purpose: types for the ternary line activation signalling block
// Assumes: nothing
// Notes: ternary symbol coding is two bits
`default_nettype none
package line_act_pkg;
  typedef enum logic [1:0] {
    SYM_ZERO = 2'h0,
    SYM_PLUS = 2'h1,
    SYM_MINUS = 2'h2
  } tern_t;
  typedef enum logic [6:0] {
    ST_SILENCE = 7'h01,
    ST_WAKE = 7'h02,
    ST_WAKE_DONE = 7'h04,
    ST_UNFRAMED = 7'h08,
    ST_FRAMED_IDLE = 7'h10,
    ST_LINK_SYNC = 7'h20,
    ST_TRANSPARENT = 7'h40
  } line_state_t;
  typedef struct packed {
    logic [7:0] b1;
    logic [7:0] b2;
    logic [1:0] d;
  } user_word_t;
  typedef struct packed {
    logic silence;
    logic framed_training;
    logic transparent_req;
    logic m_valid;
    logic m_bit;
  } rx_info_t;
  typedef struct packed {
    logic a_bit;
    user_word_t data;
  } bus_frame_t;
endpackage
`default_nettype wire

// File: core/ternary_line_activation_signaling.sv
// Purpose: activation element generator/detector with test loopback
// Assumes: receiver and bus transceiver logic share ref_clk
// Notes: scrambler taps and seed come from the cfg header, symbol coding from the package
`include "line_act_cfg.svh"
`default_nettype none
module ternary_line_activation_signaling #(
  parameter int WAKE_CYCLES = $rtoi(`WAKE_DUR_MS * `CLK_HZ / 1000.0 + 0.5),
  parameter int HALF_CYCLES = $rtoi(`CLK_HZ / (2.0 * `WAKE_TONE_HZ))
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // local wake control
  input wire logic wake_req,
  output logic wake_tone_done,
  // downstream element detection from the line receiver
  input wire line_act_pkg::rx_info_t rx_info,
  input wire logic rx_pay_valid,
  input wire line_act_pkg::user_word_t rx_pay,
  // command/indication channel to the bus transceiver
  input wire logic [3:0] upstream_command_line,
  output logic [3:0] downstream_command_line,
  // user data from the bus transceiver
  input wire logic user_up_valid,
  input wire line_act_pkg::user_word_t user_up,
  output logic user_up_ready,
  // user data toward the bus transceiver
  output logic bus_frame_valid,
  output line_act_pkg::bus_frame_t bus_frame,
  // upstream maintenance channel sources
  input wire logic m_up_bit,
  input wire logic code_err,
  // line transmitter
  input wire logic tx_ready,
  output line_act_pkg::tern_t tx_sym,
  output logic loop_closed
);
  line_act_pkg::line_state_t state_reg, state_next;
  logic [19:0] tone_cnt_reg;
  logic [14:0] half_cnt_reg;
  logic tone_level_reg;
  logic done_reg;
  logic [6:0] pos_reg;
  logic [22:0] lfsr_reg;
  logic ami_pol_reg;
  logic [7:0] m_shift_reg;
  logic loop_reg;
  logic code_err_reg;
  logic [3:0] dn_ci_reg;
  logic [17:0] ser_reg;
  logic [4:0] ser_cnt_reg;
  line_act_pkg::tern_t sym_reg;
  logic frame_vld_reg;
  line_act_pkg::bus_frame_t frame_reg;
  // two-entry buffer
  line_act_pkg::user_word_t buf_mem [0:1];
  logic wr_ptr_reg, rd_ptr_reg;
  logic [1:0] cnt_reg;

  // state decode
  wire in_silence = (state_reg == line_act_pkg::ST_SILENCE);
  wire in_wake = (state_reg == line_act_pkg::ST_WAKE);
  wire in_wake_done = (state_reg == line_act_pkg::ST_WAKE_DONE);
  wire in_unframed = (state_reg == line_act_pkg::ST_UNFRAMED);
  wire in_idle = (state_reg == line_act_pkg::ST_FRAMED_IDLE);
  wire in_link = (state_reg == line_act_pkg::ST_LINK_SYNC);
  wire in_transp = (state_reg == line_act_pkg::ST_TRANSPARENT);
  wire framed = in_idle | in_link | in_transp;
  wire quiet = in_silence | in_wake | in_wake_done;

  // bus side status
  wire up_act = (upstream_command_line == `CI_ACT_IND);
  wire up_resync = (upstream_command_line == `CI_RESYNC_IND);
  wire up_deact = (upstream_command_line == `CI_DEACT_CONF);
  // loop-induced resync keeps the terminal counted as active
  wire te_sync = up_act | (up_resync & loop_reg);

  // wake tone timing
  wire tone_end = (tone_cnt_reg == 20'(WAKE_CYCLES - 1));
  wire half_end = (half_cnt_reg == 15'(HALF_CYCLES - 1));

  // frame position decode
  wire pos_last = (pos_reg == `FRAME_SYMS - 7'h01);
  wire is_sync = framed & (pos_reg < `SYNC_SYMS);
  wire is_m = framed & (pos_reg == `M_POS);
  wire is_pay = (in_unframed | framed) & ~is_sync & ~is_m;
  wire pay_step = tx_ready & is_pay;
  wire [3:0] sync_idx = pos_reg[3:0];
  wire [21:0] sync_word = `SYNC_WORD;
  wire [4:0] sync_sh = 5'(5'd20 - {sync_idx, 1'b0});
  wire [1:0] sync_bits = 2'(sync_word >> sync_sh);

  // maintenance channel loop command decode
  wire [7:0] m_shift_next = {m_shift_reg[6:0], rx_info.m_bit};
  wire m_take = rx_info.m_valid & (framed | in_unframed);
  wire loop_close_hit = m_take & (m_shift_next == `LOOP_CLOSE_CODE);
  wire loop_open_hit = m_take & (m_shift_next == `LOOP_OPEN_CODE);
  wire loop_act = loop_reg & in_transp;

  // upstream buffer source: looped data replaces bus data
  wire src_valid = loop_act ? rx_pay_valid : user_up_valid;
  wire [17:0] src_word = loop_act ? rx_pay : user_up;
  wire buf_in_ready = (cnt_reg != 2'h2);
  wire buf_out_valid = (cnt_reg != 2'h0);
  wire push = src_valid & buf_in_ready;
  wire [17:0] buf_head = buf_mem[rd_ptr_reg];

  // serializer feeding payload symbols in transparent state
  wire ser_has = (ser_cnt_reg != 5'h00);
  wire pop = pay_step & in_transp & ~ser_has & buf_out_valid;
  wire user_bit = ser_has ? ser_reg[17] : (buf_out_valid ? buf_head[17] :
    1'b1);

  // binary data before scrambling per element
  wire pay_bit = in_transp ? user_bit : in_link;
  wire scr_fb = ^(lfsr_reg & `SCRAM_TAPS);
  wire scr_bit = pay_bit ^ lfsr_reg[22];
  wire ami_flip = pay_step & scr_bit;

  // payload and maintenance symbols
  line_act_pkg::tern_t pay_sym, m_sym, sym_next;
  assign pay_sym = scr_bit ? (ami_pol_reg ? line_act_pkg::SYM_MINUS :
    line_act_pkg::SYM_PLUS) : line_act_pkg::SYM_ZERO;
  assign m_sym = code_err_reg ? line_act_pkg::SYM_MINUS :
    (m_up_bit ? line_act_pkg::SYM_PLUS :
    line_act_pkg::SYM_ZERO);

  always_comb begin
    sym_next = line_act_pkg::SYM_ZERO;
    if (in_wake & ~tone_end) begin
      sym_next = tone_level_reg ? line_act_pkg::SYM_PLUS :
        line_act_pkg::SYM_MINUS;
    end else if (quiet) begin
      sym_next = line_act_pkg::SYM_ZERO;
    end else if (is_sync) begin
      sym_next = line_act_pkg::tern_t'(sync_bits);
    end else if (is_m) begin
      sym_next = m_sym;
    end else begin
      sym_next = pay_sym;
    end
  end

  // activation state machine
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      line_act_pkg::ST_SILENCE: begin
        if (wake_req) begin
          state_next = line_act_pkg::ST_WAKE;
        end else if (!rx_info.silence) begin
          state_next = line_act_pkg::ST_UNFRAMED;
        end
      end
      line_act_pkg::ST_WAKE: begin
        if (tone_end) begin
          state_next = line_act_pkg::ST_WAKE_DONE;
        end
      end
      line_act_pkg::ST_WAKE_DONE: begin
        if (!rx_info.silence) begin
          state_next = line_act_pkg::ST_UNFRAMED;
        end
      end
      line_act_pkg::ST_UNFRAMED: begin
        if (rx_info.silence) begin
          state_next = line_act_pkg::ST_SILENCE;
        end else if (rx_info.framed_training) begin
          state_next = line_act_pkg::ST_FRAMED_IDLE;
        end
      end
      line_act_pkg::ST_FRAMED_IDLE: begin
        if (rx_info.silence) begin
          state_next = line_act_pkg::ST_SILENCE;
        end else if (te_sync) begin
          state_next = line_act_pkg::ST_LINK_SYNC;
        end
      end
      line_act_pkg::ST_LINK_SYNC: begin
        if (rx_info.silence) begin
          state_next = line_act_pkg::ST_SILENCE;
        end else if (rx_info.transparent_req) begin
          state_next = line_act_pkg::ST_TRANSPARENT;
        end else if (!te_sync) begin
          state_next = line_act_pkg::ST_FRAMED_IDLE;
        end
      end
      line_act_pkg::ST_TRANSPARENT: begin
        if (rx_info.silence) begin
          state_next = line_act_pkg::ST_SILENCE;
        end
      end
      default: begin
        state_next = line_act_pkg::ST_SILENCE;
      end
    endcase
  end

  // downstream command code toward the bus transceiver
  logic [3:0] dn_ci_next;
  always_comb begin
    dn_ci_next = `CI_DEACT_REQ;
    if (quiet | in_unframed) begin
      dn_ci_next = up_deact ? `CI_DEACT_CONF : `CI_DEACT_REQ;
    end else if (in_transp) begin
      dn_ci_next = loop_reg ? `CI_LOOP_ACT_IND :
        `CI_ACT_IND;
    end else begin
      dn_ci_next = loop_reg ? `CI_LOOP_ACT_REQ :
        `CI_ACT_REQ;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= line_act_pkg::ST_SILENCE;
      dn_ci_reg <= `CI_DEACT_REQ;
    end else begin
      state_reg <= state_next;
      dn_ci_reg <= dn_ci_next;
    end
  end

  // wake tone generator
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tone_cnt_reg <= 20'h00000;
      half_cnt_reg <= 15'h0000;
      tone_level_reg <= 1'b1;
    end else if (in_wake) begin
      tone_cnt_reg <= tone_cnt_reg + 20'h00001;
      half_cnt_reg <= half_end ? 15'h0000 : half_cnt_reg + 15'h0001;
      tone_level_reg <= half_end ? ~tone_level_reg : tone_level_reg;
    end else begin
      tone_cnt_reg <= 20'h00000;
      half_cnt_reg <= 15'h0000;
      tone_level_reg <= 1'b1;
    end
  end

  // done flag: set at tone end, held until the line leaves wake-done
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      done_reg <= 1'b0;
    end else if (in_wake & tone_end) begin
      done_reg <= 1'b1;
    end else if (!in_wake_done) begin
      done_reg <= 1'b0;
    end
  end

  // frame position, scrambler and line polarity
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pos_reg <= 7'h00;
      lfsr_reg <= `SCRAM_SEED;
      ami_pol_reg <= 1'b0;
    end else if (quiet) begin
      pos_reg <= 7'h00;
      lfsr_reg <= `SCRAM_SEED;
      ami_pol_reg <= 1'b0;
    end else if (tx_ready) begin
      pos_reg <= pos_last ? 7'h00 : pos_reg + 7'h01;
      if (is_pay) begin
        lfsr_reg <= {lfsr_reg[21:0], scr_fb};
      end
      ami_pol_reg <= ami_pol_reg ^ ami_flip;
    end
  end

  // line symbol register; the tone changes level on the clock
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sym_reg <= line_act_pkg::SYM_ZERO;
    end else if (tx_ready | in_wake) begin
      sym_reg <= sym_next;
    end
  end

  // maintenance shift register and loop state
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      m_shift_reg <= 8'h00;
      loop_reg <= 1'b0;
    end else begin
      if (m_take) begin
        m_shift_reg <= m_shift_next;
      end
      if (quiet | in_unframed) begin
        loop_reg <= 1'b0;
      end else if (loop_close_hit) begin
        loop_reg <= 1'b1;
      end else if (loop_open_hit) begin
        loop_reg <= 1'b0;
      end
    end
  end

  // code error flag; a new error wins over the clear when sent
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      code_err_reg <= 1'b0;
    end else if (code_err) begin
      code_err_reg <= 1'b1;
    end else if (tx_ready & is_m) begin
      code_err_reg <= 1'b0;
    end
  end

  // two-entry buffer storage, one slot per entry
  generate
    for (genvar i = 0; i < 2; i++) begin : g_slot
      always_ff @(posedge ref_clk) begin
        if (push && (wr_ptr_reg == 1'(i))) begin
          buf_mem[i] <= src_word;
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      cnt_reg <= 2'h0;
    end else begin
      wr_ptr_reg <= wr_ptr_reg ^ push;
      rd_ptr_reg <= rd_ptr_reg ^ pop;
      cnt_reg <= 2'(cnt_reg + {1'b0, push} - {1'b0, pop});
    end
  end

  // serializer: whole words keep B and D aligned
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ser_reg <= 18'h00000;
      ser_cnt_reg <= 5'h00;
    end else if (!in_transp) begin
      ser_cnt_reg <= 5'h00;
    end else if (pay_step) begin
      if (ser_has) begin
        ser_reg <= {ser_reg[16:0], 1'b0};
        ser_cnt_reg <= ser_cnt_reg - 5'h01;
      end else if (buf_out_valid) begin
        ser_reg <= {buf_head[16:0], 1'b0};
        ser_cnt_reg <= `WORD_BITS - 5'h01;
      end
    end
  end

  // downstream data to the bus: passed onward even while looped
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_vld_reg <= 1'b0;
      frame_reg <= '0;
    end else begin
      frame_vld_reg <= rx_pay_valid;
      frame_reg.a_bit <= in_transp & te_sync;
      frame_reg.data <= in_transp ? rx_pay : '0;
    end
  end

  // outputs
  assign wake_tone_done = done_reg;
  assign downstream_command_line = dn_ci_reg;
  assign user_up_ready = loop_act | buf_in_ready;
  assign bus_frame_valid = frame_vld_reg;
  assign bus_frame = frame_reg;
  assign tx_sym = sym_reg;
  assign loop_closed = loop_act;
endmodule
`default_nettype wire

// File: verification/line_act_checker.sv
// Purpose: port assertions for the line activation block
// Assumes: one clock, rst_n async active low
// Notes: bound into every instance of the block
`default_nettype none
module line_act_checker #(
  parameter int WAKE_CYCLES = 40,
  parameter int HALF_CYCLES = 5
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // watched ports
  input wire logic wake_tone_done,
  input wire line_act_pkg::rx_info_t rx_info,
  input wire logic rx_pay_valid,
  input wire logic [3:0] downstream_command_line,
  input wire logic user_up_ready,
  input wire logic bus_frame_valid,
  input wire line_act_pkg::bus_frame_t bus_frame,
  input wire line_act_pkg::tern_t tx_sym,
  input wire logic loop_closed
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic [31:0] run_reg;
  logic [31:0] run_next;
  wire sym_zero = tx_sym == line_act_pkg::SYM_ZERO;
  wire [3:0] cmd = downstream_command_line;
  // length of the current run of non-zero symbols
  assign run_next = sym_zero ? 32'h0 : run_reg + 32'h1;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) run_reg <= 32'h0;
    else run_reg <= run_next;
  end
  a_tone_length: assert property ($rose(wake_tone_done) |->
    $past(run_reg) + 4 >= WAKE_CYCLES && $past(run_reg) <= WAKE_CYCLES + 2)
    else $error("wake tone length off");
  a_done_line_zero: assert property (wake_tone_done |-> sym_zero)
    else $error("line not at zero after tone");
  a_cmd_code_set: assert property (cmd inside {4'h0, 4'h8, 4'hA,
    4'hC, 4'hE, 4'hF}) else $error("unknown command code");
  a_loop_ind_code: assert property (loop_closed && $past(loop_closed)
    |-> cmd == 4'hE) else $error("loop indication code wrong");
  a_frame_follows: assert property (rx_pay_valid |=> bus_frame_valid)
    else $error("received word not passed on");
  a_no_stray_frame: assert property (!rx_pay_valid |=> !bus_frame_valid)
    else $error("frame without received word");
  a_idle_frame_zero: assert property (bus_frame_valid && cmd == 4'h8 &&
    $past(cmd) == 4'h8 |-> bus_frame == '0)
    else $error("bus frame not zero before activation");
  a_silence_answer: assert property (cmd[3] && rx_info.silence
    |-> ##[1:3] cmd inside {4'h0, 4'hF}) else $error("no deactivation");
  a_no_self_deact: assert property (cmd == 4'h8 && !rx_info.silence &&
    !$past(rx_info.silence) |=> cmd != 4'h0) else $error("self deactivated");
  a_loop_ready_high: assert property (loop_closed |-> user_up_ready)
    else $error("upstream refused while looped");
  cover property ($rose(wake_tone_done));
  cover property (loop_closed);
  cover property (bus_frame_valid && bus_frame.a_bit);
endmodule
bind ternary_line_activation_signaling line_act_checker #(
  .WAKE_CYCLES(WAKE_CYCLES),
  .HALF_CYCLES(HALF_CYCLES)
) chk (.ref_clk, .rst_n, .wake_tone_done, .rx_info, .rx_pay_valid,
  .downstream_command_line, .user_up_ready, .bus_frame_valid, .bus_frame,
  .tx_sym, .loop_closed);
`default_nettype wire

// File: verification/lt_model.sv
// Purpose: exchange side model feeding receiver detections
// Assumes: detections are levels on ref_clk
// Notes: driven through its tasks by the bench
`default_nettype none
module lt_model (
  // clock
  input wire logic ref_clk,
  // receiver view of the line
  output line_act_pkg::rx_info_t rx_info,
  output logic rx_pay_valid,
  output line_act_pkg::user_word_t rx_pay
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    rx_info = '0;
    rx_info.silence = 1'b1;
    rx_pay_valid = 1'b0;
    rx_pay = '0;
  end
  task automatic step();
    @(posedge ref_clk);
    #1;
  endtask
  // framed training goes out after the device trains unframed
  task automatic set_elem(input logic sil, input logic trn, input logic trq);
    step();
    rx_info.silence = sil;
    rx_info.framed_training = trn;
    rx_info.transparent_req = trq;
  endtask
  task automatic send_m(input logic [7:0] code);
    for (int i = 7; i >= 0; i--) begin
      step();
      rx_info.m_bit = code[i];
      rx_info.m_valid = 1'b1;
      step();
      rx_info.m_valid = 1'b0;
      rx_info.m_bit = ~code[i];
    end
  endtask
  task automatic send_word(input line_act_pkg::user_word_t w);
    step();
    rx_pay = w;
    rx_pay_valid = 1'b1;
    step();
    rx_pay_valid = 1'b0;
    rx_pay = ~w;
  endtask
endmodule
`default_nettype wire

// File: verification/ternary_line_activation_signaling_test.sv
// Purpose: self-checking bench for the line activation block
// Assumes: short wake counts, exchange model on the receive side
// Notes: symbols are collected at every tx_ready strobe
`default_nettype none
module ternary_line_activation_signaling_test;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int WAKE = 40;
  localparam int HALF = 5;
  localparam line_act_pkg::tern_t Z = line_act_pkg::SYM_ZERO;
  logic ref_clk, rst_n, wake_req, wake_tone_done, rx_pay_valid;
  logic user_up_valid, user_up_ready, bus_frame_valid, m_up_bit;
  logic code_err, tx_ready, tx_run, loop_closed;
  logic [3:0] upstream_command_line, downstream_command_line;
  logic [23:0] hist;
  line_act_pkg::rx_info_t rx_info;
  line_act_pkg::user_word_t rx_pay, user_up;
  line_act_pkg::bus_frame_t bus_frame;
  line_act_pkg::tern_t tx_sym, m_seen;
  int err_total, n_checks, n_sync, cyc;
  ternary_line_activation_signaling #(.WAKE_CYCLES(WAKE), .HALF_CYCLES(HALF))
  dut (.ref_clk, .rst_n, .wake_req, .wake_tone_done, .rx_info,
    .rx_pay_valid, .rx_pay, .upstream_command_line, .downstream_command_line,
    .user_up_valid, .user_up, .user_up_ready, .bus_frame_valid, .bus_frame,
    .m_up_bit, .code_err, .tx_ready, .tx_sym, .loop_closed);
  lt_model lt (.ref_clk, .rx_info, .rx_pay_valid, .rx_pay);
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    #1 tx_ready = tx_run & ~tx_ready;
  end
  // sync word +++---+--+- as 2-bit symbols
  always @(posedge ref_clk) begin
    if (tx_ready) begin
      #2 hist = {hist[21:0], tx_sym};
      // symbol just before the sync word is the M slot
      if (hist[21:0] == 22'h15A9A6) begin
        n_sync++;
        m_seen = line_act_pkg::tern_t'(hist[23:22]);
      end
    end
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
      input string what);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %0t %s: %0h not %0h", $time, what, seen, exp);
    end
  endtask
  task automatic step();
    @(posedge ref_clk);
    #1;
  endtask
  task automatic wait_sync(input int k);
    for (int i = 0; i < 1000 && n_sync < k; i++) step();
  endtask
  task automatic wait_cmd(input logic [3:0] c, input int lim, string w);
    for (int i = 0; i < lim && downstream_command_line !== c; i++) step();
    check(downstream_command_line, c, w);
  endtask
  task automatic t_wake();
    int n;
    int run;
    n = 0;
    run = 0;
    wake_req = 1'b1;
    step();
    wake_req = 1'b0;
    while (tx_sym !== line_act_pkg::SYM_PLUS && n < 10) begin
      step();
      n++;
    end
    while (tx_sym === line_act_pkg::SYM_PLUS && run < WAKE) begin
      step();
      run++;
    end
    check(run, HALF, "tone half period");
    for (n = run; wake_tone_done !== 1'b1 && n < 2 * WAKE; n++) step();
    check(n >= WAKE - 3 && n <= WAKE + 3, 1, "tone duration");
    repeat (4) begin
      step();
      check(tx_sym, Z, "zero after tone");
    end
    check(wake_tone_done, 1'b1, "tone done flag");
    $display("test wake done");
  endtask
  task automatic t_train();
    lt.set_elem(1'b0, 1'b0, 1'b0);
    n_sync = 0;
    repeat (600) step();
    check(n_sync, 0, "sync word while unframed");
    check(downstream_command_line, 4'h0, "code while unframed");
    check(wake_tone_done, 1'b0, "tone flag after leaving");
    lt.set_elem(1'b0, 1'b1, 1'b0);
    wait_cmd(4'h8, 8, "framed idle code");
    n_sync = 0;
    repeat (600) step();
    check(n_sync >= 2, 1, "sync words in framed idle");
    m_up_bit = 1'b1;
    n_sync = 0;
    wait_sync(1);
    code_err = 1'b1;
    step();
    code_err = 1'b0;
    wait_sync(2);
    check(m_seen, line_act_pkg::SYM_MINUS, "code error in M slot");
    wait_sync(3);
    check(m_seen, line_act_pkg::SYM_PLUS, "M data bit");
    m_up_bit = 1'b0;
    lt.send_m(8'hA5);
    wait_cmd(4'hA, 24, "loop request code");
    lt.send_m(8'h5A);
    wait_cmd(4'h8, 24, "loop opened code");
    upstream_command_line = 4'hC;
    repeat (4) step();
    check(downstream_command_line, 4'h8, "link sync code");
    lt.send_word(18'h2A5C3);
    check(bus_frame_valid, 1'b1, "idle frame strobe");
    check(bus_frame, '0, "idle frame content");
    $display("test training done");
  endtask
  task automatic t_transp();
    int n;
    lt.set_elem(1'b0, 1'b1, 1'b1);
    wait_cmd(4'hC, 8, "transparent code");
    lt.send_word(18'h1B7E4);
    check(bus_frame, {1'b1, 18'h1B7E4}, "user frame");
    tx_run = 1'b0;
    n = 0;
    user_up = 18'h0C3A1;
    user_up_valid = 1'b1;
    repeat (6) begin
      if (user_up_ready === 1'b1) n++;
      step();
      user_up = user_up + 18'h1;
    end
    user_up_valid = 1'b0;
    check(n, 2, "words taken before refusal");
    tx_run = 1'b1;
    for (n = 0; n < 2000 && user_up_ready !== 1'b1; n++) step();
    check(user_up_ready, 1'b1, "buffer drained to line");
    $display("test transparent done");
  endtask
  task automatic t_loop();
    lt.send_m(8'hA5);
    wait_cmd(4'hE, 24, "loop indication code");
    check(loop_closed, 1'b1, "loop held");
    check(user_up_ready, 1'b1, "upstream ignored in loop");
    lt.send_word(18'h3F00F);
    check(bus_frame_valid, 1'b1, "looped word passed on");
    upstream_command_line = 4'h4;
    repeat (3) step();
    check(downstream_command_line, 4'hE, "resync in loop");
    upstream_command_line = 4'hC;
    lt.send_m(8'h5A);
    wait_cmd(4'hC, 24, "loop opened code");
    $display("test loop done");
  endtask
  task automatic t_deact();
    lt.set_elem(1'b1, 1'b0, 1'b0);
    wait_cmd(4'h0, 8, "deactivation code");
    repeat (8) step();
    check(tx_sym, Z, "silence answer");
    upstream_command_line = 4'hF;
    wait_cmd(4'hF, 4, "deactivation confirmed");
    $display("test deactivation done");
  endtask
  initial begin
    {rst_n, wake_req, user_up_valid, m_up_bit, code_err} = '0;
    {tx_ready, tx_run, hist, cyc, err_total, n_checks} = '0;
    upstream_command_line = 4'h0;
    user_up = '0;
    repeat (10) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    tx_run = 1'b1;
    check(downstream_command_line, 4'h0, "reset code");
    check(user_up_ready, 1'b1, "reset ready");
    t_wake();
    t_train();
    t_transp();
    t_loop();
    t_deact();
    give_verdict();
  end
endmodule
`default_nettype wire
